// [rtl/pdvc_pkg.sv]
// Overview of operation
// - Shift chain validity period register, eight bits.
// - Serial port validity period register, own address.
// - Network validity period register, own address.
// - Zero period never times out, default zero.
// - Period one to 255 gives milliseconds limit.
// - Missed production within period marks data invalid.
// - Outputs from invalid area switch to safe values.
// - Safe field: zeros, ones, or hold last.
// - Shift chain usage config, default three.
// - Bits two, one select reserved input registers.
// - Bit zero reserves output register for lamps.
// - Current shift chain assignment reported separately.
// - Script enable: zero off, one on, default zero.
// - Script port selects serial interface for script.
package pdvc_pkg;
	localparam logic [15:0] ADDR_SHIFT_VALID = 16'h0022;
	localparam logic [15:0] ADDR_SERIAL_VALID = 16'h0023;
	localparam logic [15:0] ADDR_NET_VALID = 16'h0024;
	localparam logic [15:0] ADDR_USAGE_CFG = 16'h0025;
	localparam logic [15:0] ADDR_USAGE_CUR = 16'h0026;
	localparam logic [15:0] ADDR_SCRIPT_EN = 16'h0032;
	localparam logic [15:0] ADDR_SCRIPT_PORT = 16'h0033;
	localparam logic [7:0] RST_VALID = 8'h00;
	localparam logic [7:0] RST_USAGE = 8'h03;
	localparam logic [7:0] RST_SCRIPT_EN = 8'h00;
	localparam logic [7:0] RST_SCRIPT_PORT = 8'h01;
	localparam logic [7:0] USAGE_MASK = 8'h07;
	localparam logic [1:0] SAFE_ZEROS = 2'h0;
	localparam logic [1:0] SAFE_ONES = 2'h1;
	localparam logic [1:0] SAFE_HOLD = 2'h2;
	localparam int CLK_HZ = 100000000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int NUM_IF = 3;
	typedef enum logic [1:0] {PDVC_IDLE, PDVC_RUN, PDVC_EXPIRED} pdvc_tmr_t;
endpackage

// [rtl/pdvc_ms_tick.sv]
`timescale 1ns/1ns
// Divider making a one-cycle enable every millisecond.
module pdvc_ms_tick #(
	parameter int CYCLES = pdvc_pkg::MS_CYCLES
) (
	input  wire logic mclk_in,   // System clock.
	input  wire logic resetn_in, // Asynchronous reset, active low.
	output logic      tick_out   // One-cycle millisecond pulse.
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        tick_nxt;

	// Count down and pulse at wrap.
	always_comb begin
		tick_nxt = (cnt_r == 32'h0);
		cnt_nxt = tick_nxt ? 32'(CYCLES - 1) : cnt_r - 32'h1;
	end

	// Register the divider.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= 32'h0;
			tick_out <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_out <= tick_nxt;
		end
	end
endmodule

// [rtl/pdvc_top.sv]
`timescale 1ns/1ns
// Validity timers, shift chain usage and script configuration registers.
module pdvc_top #(
	parameter int MS_CYCLES = pdvc_pkg::MS_CYCLES,
	parameter int DW        = 8
) (
	input  wire logic          mclk_in,           // 100 MHz clock.
	input  wire logic          resetn_in,         // Asynchronous reset, active low.
	input  wire logic [15:0]   reg_addr_in,       // Register address.
	input  wire logic          reg_wr_in,         // Write strobe, one cycle.
	input  wire logic          reg_rd_in,         // Read strobe, one cycle.
	input  wire logic [7:0]    reg_wdata_in,      // Write data.
	output logic [7:0]         reg_rdata_out,     // Read data, next cycle.
	output logic               reg_ack_out,       // Read or write answered.
	output logic               reg_err_out,       // Unmapped address.
	input  wire logic          apply_in,          // Firmware commits staged values.
	input  wire logic [7:0]    nv_shift_valid_in, // Retained shift period.
	input  wire logic [7:0]    nv_serial_valid_in,// Retained serial period.
	input  wire logic [7:0]    nv_net_valid_in,   // Retained network period.
	input  wire logic [7:0]    nv_usage_in,       // Retained usage config.
	input  wire logic [7:0]    nv_script_en_in,   // Retained script enable.
	input  wire logic [7:0]    nv_script_port_in, // Retained script port.
	input  wire logic          nv_load_in,        // Load retained values, one cycle.
	input  wire logic [2:0]    produce_in,        // New production per interface.
	input  wire logic [5:0]    safe_sel_in,       // Two-bit safe field per interface.
	input  wire logic [3*DW-1:0] copy_data_in,    // Copied output data per interface.
	input  wire logic [2:0]    copy_src_in,       // Source interface feeding each output.
	output logic [2:0]         data_valid_out,    // Input data valid per interface.
	output logic [3*DW-1:0]    out_data_out,      // Output data after safe substitution.
	output logic [1:0]         in_reserve_out,    // Reserved input register usage.
	output logic               led_reserve_out,   // Output register 0 drives lamps.
	output logic               script_run_out,    // Script execution active.
	output logic               script_port_out    // Script serial port select.
);
	logic [7:0] period_r [3];
	logic [7:0] period_nxt [3];
	logic [7:0] usage_cfg_r, usage_cfg_nxt;
	logic [7:0] usage_cur_r, usage_cur_nxt;
	logic [7:0] script_en_r, script_en_nxt;
	logic [7:0] script_port_r, script_port_nxt;
	logic [7:0] rdata_nxt;
	logic       ack_nxt, err_nxt;
	logic       ms_tick;

	// Millisecond enable for all timers.
	pdvc_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.mclk_in  (mclk_in),
		.resetn_in(resetn_in),
		.tick_out (ms_tick)
	);

	// Register decode. Usage config writes are staged; apply copies them into force. Other writes take effect at once.
	always_comb begin
		for (int i = 0; i < 3; i++) period_nxt[i] = period_r[i];
		usage_cfg_nxt = usage_cfg_r;
		usage_cur_nxt = usage_cur_r;
		script_en_nxt = script_en_r;
		script_port_nxt = script_port_r;
		rdata_nxt = 8'h00;
		ack_nxt = reg_wr_in | reg_rd_in;
		err_nxt = 1'b0;
		if (nv_load_in) begin
			period_nxt[0] = nv_shift_valid_in;
			period_nxt[1] = nv_serial_valid_in;
			period_nxt[2] = nv_net_valid_in;
			usage_cfg_nxt = nv_usage_in & pdvc_pkg::USAGE_MASK;
			usage_cur_nxt = nv_usage_in & pdvc_pkg::USAGE_MASK;
			script_en_nxt = nv_script_en_in;
			script_port_nxt = nv_script_port_in;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				pdvc_pkg::ADDR_SHIFT_VALID: period_nxt[0] = reg_wdata_in;
				pdvc_pkg::ADDR_SERIAL_VALID: period_nxt[1] = reg_wdata_in;
				pdvc_pkg::ADDR_NET_VALID: period_nxt[2] = reg_wdata_in;
				pdvc_pkg::ADDR_USAGE_CFG: usage_cfg_nxt = reg_wdata_in & pdvc_pkg::USAGE_MASK;
				pdvc_pkg::ADDR_USAGE_CUR: usage_cur_nxt = reg_wdata_in & pdvc_pkg::USAGE_MASK;
				pdvc_pkg::ADDR_SCRIPT_EN: script_en_nxt = reg_wdata_in;
				pdvc_pkg::ADDR_SCRIPT_PORT: script_port_nxt = reg_wdata_in;
				default: err_nxt = 1'b1;
			endcase
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				pdvc_pkg::ADDR_SHIFT_VALID: rdata_nxt = period_r[0];
				pdvc_pkg::ADDR_SERIAL_VALID: rdata_nxt = period_r[1];
				pdvc_pkg::ADDR_NET_VALID: rdata_nxt = period_r[2];
				pdvc_pkg::ADDR_USAGE_CFG: rdata_nxt = usage_cfg_r;
				pdvc_pkg::ADDR_USAGE_CUR: rdata_nxt = usage_cur_r;
				pdvc_pkg::ADDR_SCRIPT_EN: rdata_nxt = script_en_r;
				pdvc_pkg::ADDR_SCRIPT_PORT: rdata_nxt = script_port_r;
				default: err_nxt = 1'b1;
			endcase
		end
		if (apply_in && !nv_load_in) usage_cur_nxt = usage_cfg_nxt;
	end

	// Register bank state.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < 3; i++) period_r[i] <= pdvc_pkg::RST_VALID;
			usage_cfg_r <= pdvc_pkg::RST_USAGE;
			usage_cur_r <= pdvc_pkg::RST_USAGE;
			script_en_r <= pdvc_pkg::RST_SCRIPT_EN;
			script_port_r <= pdvc_pkg::RST_SCRIPT_PORT;
			reg_rdata_out <= 8'h00;
			reg_ack_out <= 1'b0;
			reg_err_out <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++) period_r[i] <= period_nxt[i];
			usage_cfg_r <= usage_cfg_nxt;
			usage_cur_r <= usage_cur_nxt;
			script_en_r <= script_en_nxt;
			script_port_r <= script_port_nxt;
			reg_rdata_out <= rdata_nxt;
			reg_ack_out <= ack_nxt;
			reg_err_out <= err_nxt;
		end
	end

	// Usage and script outputs follow the values in force.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			in_reserve_out <= 2'h0;
			led_reserve_out <= 1'b0;
			script_run_out <= 1'b0;
			script_port_out <= 1'b0;
		end else begin
			in_reserve_out <= usage_cur_r[2:1];
			led_reserve_out <= usage_cur_r[0];
			script_run_out <= (script_en_r == 8'h01);
			script_port_out <= script_port_r[0];
		end
	end

	// One validity timer and one safe-value output stage per interface.
	for (genvar g = 0; g < pdvc_pkg::NUM_IF; g++) begin : g_if
		logic [7:0] ms_r, ms_nxt;
		logic       valid_r, valid_nxt;
		logic [DW-1:0] held_r, held_nxt, out_nxt;
		logic [1:0] sel;
		logic       src_ok;

		// Count elapsed milliseconds since the last production.
		always_comb begin
			ms_nxt = ms_r;
			valid_nxt = valid_r;
			if (produce_in[g]) begin
				ms_nxt = 8'h00;
				valid_nxt = 1'b1;
			end else if (period_r[g] == 8'h00) begin
				valid_nxt = 1'b1;
				ms_nxt = 8'h00;
			end else if (ms_tick && valid_r) begin
				if (ms_r >= period_r[g]) begin
					valid_nxt = 1'b0;
				end else begin
					ms_nxt = ms_r + 8'h01;
				end
			end
		end

		// Pick the fallback data while the feeding area is invalid.
		always_comb begin
			sel = safe_sel_in[2*g +: 2];
			src_ok = valid_r;
			held_nxt = held_r;
			out_nxt = copy_data_in[DW*g +: DW];
			if (copy_src_in[g] && !src_ok) begin
				case (sel)
					pdvc_pkg::SAFE_ZEROS: out_nxt = '0;
					pdvc_pkg::SAFE_ONES: out_nxt = '1;
					pdvc_pkg::SAFE_HOLD: out_nxt = held_r;
					default: out_nxt = '0;
				endcase
			end else begin
				held_nxt = copy_data_in[DW*g +: DW];
			end
		end

		// Timer and output registers. The shared tick has a free phase, so expiry may come
		// up to one millisecond late but never before the full period has elapsed.
		always_ff @(posedge mclk_in or negedge resetn_in) begin
			if (!resetn_in) begin
				ms_r <= 8'h00;
				valid_r <= 1'b1;
				held_r <= '0;
				data_valid_out[g] <= 1'b1;
				out_data_out[DW*g +: DW] <= '0;
			end else begin
				ms_r <= ms_nxt;
				valid_r <= valid_nxt;
				held_r <= held_nxt;
				data_valid_out[g] <= valid_nxt;
				out_data_out[DW*g +: DW] <= out_nxt;
			end
		end
	end
endmodule

// [verification/pdvc_chk.sv]
`timescale 1ns/1ns
// Answer handshake and substitute outputs, watched at the top's ports.
module pdvc_chk #(
	parameter int DW = 8
) (
	input wire logic            mclk_in,        // Clock.
	input wire logic            resetn_in,      // Reset.
	input wire logic            reg_wr_in,      // Write.
	input wire logic            reg_rd_in,      // Read.
	input wire logic            reg_ack_out,    // Answer.
	input wire logic            reg_err_out,    // Unmapped.
	input wire logic [7:0]      reg_rdata_out,  // Data.
	input wire logic [2:0]      produce_in,     // Productions.
	input wire logic [5:0]      safe_sel_in,    // Safe fields.
	input wire logic [2:0]      copy_src_in,    // Sources.
	input wire logic [2:0]      data_valid_out, // Valid.
	input wire logic [3*DW-1:0] out_data_out    // Outputs.
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);
	// Two steady edges, so the one-cycle output latency has settled.
	sequence s_inv(int i, logic [1:0] m);
		(copy_src_in[i] && !data_valid_out[i] && safe_sel_in[2*i +: 2] == m) [*2];
	endsequence
	AST_ACK: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out)
		else $error("no answer");
	AST_QUIET: assert property (!(reg_wr_in || reg_rd_in) |=> !reg_ack_out)
		else $error("stray answer");
	AST_ERR: assert property (reg_err_out |-> reg_ack_out && reg_rdata_out == 8'h00)
		else $error("bad refusal");
	AST_PROD0: assert property (produce_in[0] |-> ##[1:2] data_valid_out[0])
		else $error("no revalidation");
	AST_PROD2: assert property (produce_in[2] |-> ##[1:2] data_valid_out[2])
		else $error("no revalidation");
	AST_ONES: assert property (s_inv(1, 2'h1) |-> out_data_out[2*DW-1:DW] == '1)
		else $error("ones expected");
	AST_ZEROS: assert property (s_inv(0, 2'h0) |-> out_data_out[DW-1:0] == '0)
		else $error("zeros expected");
	AST_HOLD: assert property (s_inv(2, 2'h2) ##1 s_inv(2, 2'h2)
		|-> $stable(out_data_out[3*DW-1:2*DW])) else $error("held data moved");
endmodule

// [verification/pdvc_master.sv]
`timescale 1ns/1ns
// Network master model: one access at a time, strobe held one cycle, answer awaited up to four cycles.
module pdvc_master (
	input  wire logic        mclk_in,             // Clock.
	input  wire logic [7:0]  reg_rdata_out,       // Data.
	input  wire logic        reg_ack_out,         // Answer.
	input  wire logic        reg_err_out,         // Unmapped.
	output logic      [15:0] reg_addr_in = 16'h0, // Address.
	output logic             reg_wr_in = 1'b0,    // Write.
	output logic             reg_rd_in = 1'b0,    // Read.
	output logic      [7:0]  reg_wdata_in = 8'h0  // Data.
);
	// A released bus shows the inverse, so a stale value can never match.
	task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] rq, output logic re, output logic ok);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		ok = 1'b0;
		for (int n = 0; n < 4 && !ok; n++) begin
			@(posedge mclk_in);
			ok = (reg_ack_out === 1'b1);
		end
		rq = reg_rdata_out;
		re = reg_err_out;
		reg_addr_in <= ~a;
		reg_wdata_in <= ~d;
	endtask
endmodule

// [verification/pdvc_top_bench.sv]
`timescale 1ns/1ns
// Random and corner traffic; a short millisecond keeps the run brief.
module pdvc_top_bench;
	localparam int          MSC = 10;
	localparam logic [15:0] ADR [7] = '{16'h0022, 16'h0023, 16'h0024, 16'h0025, 16'h0026,
		16'h0032, 16'h0033};
	localparam logic [7:0]  RV [7] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h01};
	logic        mclk_in = 1'b0, resetn_in = 1'b0, apply_in = 1'b0, nv_load_in = 1'b0;
	logic        reg_wr_in, reg_rd_in, reg_ack_out, reg_err_out, e, led_reserve_out;
	logic        script_run_out, script_port_out;
	logic [15:0] reg_addr_in;
	logic [7:0]  reg_wdata_in, reg_rdata_out, q, h, v;
	logic [47:0] nv_val = 48'h0;
	logic [2:0]  produce_in = 3'h0, copy_src_in = 3'h0, data_valid_out;
	logic [5:0]  safe_sel_in = 6'h0;
	logic [23:0] copy_data_in = 24'h0, out_data_out;
	logic [1:0]  in_reserve_out, s;
	int          error_cnt = 0, cmp_count = 0, n, g;
	pdvc_top #(.MS_CYCLES(MSC)) pdvc_top_inst (.mclk_in, .resetn_in, .reg_addr_in, .reg_wr_in,
		.reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .reg_err_out, .apply_in,
		.nv_shift_valid_in(nv_val[7:0]), .nv_serial_valid_in(nv_val[15:8]),
		.nv_net_valid_in(nv_val[23:16]), .nv_usage_in(nv_val[31:24]),
		.nv_script_en_in(nv_val[39:32]), .nv_script_port_in(nv_val[47:40]), .nv_load_in,
		.produce_in, .safe_sel_in, .copy_data_in, .copy_src_in, .data_valid_out,
		.out_data_out, .in_reserve_out, .led_reserve_out, .script_run_out, .script_port_out);
	pdvc_master pdvc_master_inst (.mclk_in, .reg_rdata_out, .reg_ack_out, .reg_err_out,
		.reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in);
	// Free-running clock.
	always #5 mclk_in = ~mclk_in;
	// Compare helpers, access wrapper and run end.
	task automatic chk(input logic [7:0] o, input logic [7:0] x);
		cmp_count++;
		if (o !== x) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h want %h", $time, o, x);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		logic ok;
		pdvc_master_inst.xfer(w, a, d, q, e, ok);
		chk(8'(ok), 8'h01);
		if (!ok) complete_run();
		@(posedge mclk_in);
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge mclk_in);
		{nv_load_in, apply_in, produce_in} <= m;
		@(posedge mclk_in);
		{nv_load_in, apply_in, produce_in} <= 5'h0;
		repeat (2) @(posedge mclk_in);
	endtask
	// Usage registers keep three bits; an invalid area gives zeros, ones or held data.
	function automatic logic [7:0] wexp(input int i, input logic [7:0] d);
		return (i == 3 || i == 4) ? (d & 8'h07) : d;
	endfunction
	function automatic logic [7:0] sexp(input logic [1:0] m, input logic [7:0] d);
		return (m == 2'h1) ? 8'hff : ((m == 2'h2) ? d : 8'h00);
	endfunction
	// Defaults, read-back, commit, script, restart, then the three timers.
	initial begin
		v = 8'($urandom(32'h958935b7));
		repeat (6) @(posedge mclk_in);
		resetn_in <= 1'b1;
		for (n = 0; n < 7; n++) begin
			acc(1'b0, ADR[n], 8'h00);
			chk(q, RV[n]);
		end
		chk(8'({in_reserve_out, led_reserve_out}), 8'h03);
		repeat (300) @(posedge mclk_in);
		chk(8'(data_valid_out), 8'h07);
		for (n = 0; n < 7; n++) begin
			v = 8'($urandom);
			acc(1'b1, ADR[n], v);
			acc(1'b0, ADR[n], 8'h00);
			chk(q, wexp(n, v));
		end
		acc(1'b0, 16'h0027, 8'h00);
		chk(q, 8'h00);
		chk(8'(e), 8'h01);
		h = 8'({in_reserve_out, led_reserve_out});
		v = 8'($urandom);
		acc(1'b1, 16'h0025, v);
		chk(8'({in_reserve_out, led_reserve_out}), h);
		pulse(5'h08);
		acc(1'b0, 16'h0026, 8'h00);
		chk(q, wexp(3, v));
		chk(8'({in_reserve_out, led_reserve_out}), wexp(3, v));
		for (n = 0; n < 4; n++) begin
			acc(1'b1, 16'h0032, 8'(n));
			acc(1'b1, 16'h0033, 8'(n % 2));
			chk(8'({script_run_out, script_port_out}), 8'({n == 1, n % 2 == 1}));
		end
		acc(1'b1, 16'h0032, 8'h01);
		acc(1'b1, 16'h0032, 8'h00);
		nv_val <= {8'($urandom % 2), 8'h00, 8'($urandom % 8), 24'($urandom)};
		pulse(5'h10);
		acc(1'b0, 16'h0022, 8'h00);
		chk(q, nv_val[7:0]);
		chk(8'(script_run_out), 8'h00);
		for (g = 0; g < 3; g++) begin
			v = 8'(2 + $urandom % 4);
			s = 2'(g);
			acc(1'b1, ADR[g], v);
			safe_sel_in <= {4'h0, s} << (2 * g);
			copy_src_in <= 3'h1 << g;
			copy_data_in <= 24'($urandom);
			pulse(5'(1 << g));
			repeat (MSC * v - 3) @(posedge mclk_in);
			chk(8'(data_valid_out[g]), 8'h01);
			for (n = 0; n < 20 && data_valid_out[g] !== 1'b0; n++) @(posedge mclk_in);
			chk(8'(data_valid_out[g]), 8'h00);
			if (n == 20) complete_run();
			h = copy_data_in[8 * g +: 8];
			copy_data_in <= ~copy_data_in;
			repeat (3) @(posedge mclk_in);
			chk(out_data_out[8 * g +: 8], sexp(s, h));
			pulse(5'(1 << g));
			chk(out_data_out[8 * g +: 8], copy_data_in[8 * g +: 8]);
		end
		complete_run();
	end
endmodule
bind pdvc_top pdvc_chk #(.DW(DW)) pdvc_chk_inst (.mclk_in, .resetn_in, .reg_wr_in, .reg_rd_in,
	.reg_ack_out, .reg_err_out, .reg_rdata_out, .produce_in, .safe_sel_in, .copy_src_in,
	.data_valid_out, .out_data_out);
